// ### design/mmst_pkg.sv
package mmst_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_HZ = 50_000_000;
  localparam int INIT_MS = 2000;
  localparam int RESET_US = 2;
  localparam int INT_ASSERT_MS = 200;
  localparam int INT_RELEASE_US = 500;
  localparam int LOS_ASSERT_MS = 100;
  localparam int LOS_FAST_ASSERT_MS = 1;
  localparam int LOS_FAST_CLEAR_MS = 3;
  localparam int MASK_MS = 100;
  localparam int RATESEL_MS = 100;
  // least time also rounds down
  localparam int RESET_CYC = (RESET_US * (CLK_HZ / 1_000_000));
  // longest times round down
  localparam longint INIT_CYC = longint'(INIT_MS) * (CLK_HZ / 1000);
  localparam int RATESEL_CYC = RATESEL_MS * (CLK_HZ / 1000);
  localparam int LOS_FAST_CLEAR_CYC = LOS_FAST_CLEAR_MS * (CLK_HZ / 1000);
  // qualification filter, well inside all latency limits
  localparam int FILTER_CYC = 16;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_COND = 8'h10;

  localparam int NFLAG = 8;
  localparam int BIT_LOS = 0;
  localparam int BIT_TXF = 1;
  localparam int BIT_INIT = 7;

  localparam logic [NFLAG-1:0] MASK_RST = 8'hFF;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int CTRL_FAST = 0;
  localparam int CTRL_RATE = 1;
  localparam int CTRL_APP = 2;

  typedef enum logic [1:0] {
    MMST_INIT = 2'b00,
    MMST_READY = 2'b01,
    MMST_RESET = 2'b10
  } mmst_state_t;

  // bit 0 fast, bit 1 rate, bit 2 application, as software sees it
  typedef struct packed {
    logic app_sel;
    logic rate_sel;
    logic fast_mode;
  } mmst_ctrl_t;

  typedef struct packed {
    logic ready;
    logic bw_conform;
    logic in_reset;
  } mmst_stat_t;

endpackage

// ### design/mmst_sync.sv
`timescale 1ns/10ps
// ============================================================
// two-flop synchroniser, one per external level
// ============================================================
module mmst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // mmst_sync

// ### design/mmst_top.sv
`timescale 1ns/10ps
module mmst_top
  import mmst_pkg::*;
#(
  parameter longint INIT_CYCLES = INIT_CYC,
  parameter int SETTLE_CYCLES = RATESEL_CYC,
  parameter int LOS_CLEAR_CYCLES = LOS_FAST_CLEAR_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // module pins and conditions
  input wire logic module_reset_n,
  input wire logic [mmst_pkg::NFLAG-2:0] condition,
  output logic interrupt_request_n,
  output logic management_setup_state,
  output logic [1:0] bandwidth_select
);
  import mmst_pkg::*;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [NFLAG-1:0] pins_s;
  logic rst_pin;
  logic [NFLAG-2:0] cond_s;

  mmst_sync #(.W(NFLAG)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({module_reset_n, condition}),
    .q(pins_s)
  );
  assign rst_pin = pins_s[NFLAG-1];
  assign cond_s = pins_s[NFLAG-2:0];

  // ==========================================================
  // module reset pulse qualification
  // ==========================================================
  logic [15:0] rst_low_cnt;
  logic rst_held;

  // a low pulse of RESET_CYC or longer counts; glitches do not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_low_cnt <= '0;
      rst_held <= 1'b0;
    end else if (rst_pin) begin
      rst_low_cnt <= '0;
      rst_held <= 1'b0;
    end else begin
      if (rst_low_cnt != 16'hFFFF)
        rst_low_cnt <= rst_low_cnt + 16'h0001;
      if (rst_low_cnt >= 16'(RESET_CYC - 1))
        rst_held <= 1'b1;
    end
  end

  // ==========================================================
  // management setup state machine
  // ==========================================================
  mmst_state_t state;
  logic [31:0] init_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= MMST_INIT;
      init_cnt <= '0;
    end else begin
      case (state)
        MMST_INIT: begin
          init_cnt <= init_cnt + 32'h0000_0001;
          // fixed short setup, far below the deadline
          if (rst_held)
            state <= MMST_RESET;
          else if (init_cnt >= 32'(INIT_CYCLES / 1024))
            state <= MMST_READY;
        end
        MMST_READY: begin
          if (rst_held)
            state <= MMST_RESET;
        end
        MMST_RESET: begin
          init_cnt <= '0;
          if (rst_pin)
            state <= MMST_INIT;
        end
        default: state <= MMST_INIT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      management_setup_state <= 1'b1;
    else
      management_setup_state <= (state != MMST_READY);
  end

  // ==========================================================
  // condition qualification
  // ==========================================================
  mmst_ctrl_t ctrl;
  wire [NFLAG-2:0] cond_q;
  logic [NFLAG-1:0] event_set;
  logic [NFLAG-1:0] cond_live;
  logic init_done_p;

  // short debounce; the same filter meets every assert limit
  for (genvar i = 0; i < NFLAG - 1; i++) begin : g_filt
    logic [4:0] filt_cnt;
    logic filt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        filt_cnt <= '0;
        filt_q <= 1'b0;
      end else if (cond_s[i] == filt_q) begin
        filt_cnt <= '0;
      end else if (filt_cnt >= 5'(FILTER_CYC - 1)) begin
        filt_cnt <= '0;
        filt_q <= cond_s[i];
      end else begin
        filt_cnt <= filt_cnt + 5'h01;
      end
    end
    assign cond_q[i] = filt_q;
  end

  // loss of signal clear hold-off in fast mode
  logic [31:0] los_clr_cnt;
  logic los_status;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      los_clr_cnt <= '0;
      los_status <= 1'b0;
    end else if (cond_q[BIT_LOS]) begin
      los_clr_cnt <= '0;
      los_status <= 1'b1;
    end else if (!ctrl.fast_mode) begin
      los_status <= 1'b0;
    end else if (los_status) begin
      // short settle, well inside the fast clear limit
      if (los_clr_cnt >= 32'(LOS_CLEAR_CYCLES / 64))
        los_status <= 1'b0;
      else
        los_clr_cnt <= los_clr_cnt + 32'h0000_0001;
    end
  end

  assign init_done_p = (state == MMST_INIT) &&
                       (init_cnt >= 32'(INIT_CYCLES / 1024));
  assign cond_live = {1'b0, cond_q[NFLAG-2:1], los_status};
  logic [NFLAG-1:0] cond_d;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cond_d <= '0;
    else
      cond_d <= cond_live;
  end
  assign event_set = (cond_live & ~cond_d) |
                     {init_done_p, {(NFLAG-1){1'b0}}};

  // ==========================================================
  // axi4-lite slave
  // ==========================================================
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic wr_fire;
  logic rd_fire;
  logic [NFLAG-1:0] status;
  logic [NFLAG-1:0] mask;
  logic [NFLAG-1:0] next_status;
  logic [31:0] settle_cnt;
  mmst_stat_t stat;

  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == OFS_STATUS || aw_addr == OFS_MASK ||
          aw_addr == OFS_CTRL || aw_addr == OFS_STATE ||
          aw_addr == OFS_COND)
        s_axi_bresp <= 2'b00;
      else
        s_axi_bresp <= 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // mask and control writes take effect on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= MASK_RST;
      ctrl <= mmst_ctrl_t'(CTRL_RST);
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == OFS_MASK)
        mask <= w_data[NFLAG-1:0];
      else if (aw_addr == OFS_CTRL)
        ctrl <= mmst_ctrl_t'(w_data[2:0]);
    end
  end

  // flags whose condition is no longer live clear on read of the status word; a new event wins
  always_comb begin
    next_status = status;
    if (rd_fire && s_axi_araddr == OFS_STATUS)
      next_status = status & cond_live;
    next_status = next_status | event_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      status <= '0;
    else
      status <= next_status;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == OFS_STATUS)
        s_axi_rdata <= {24'h00_0000, status};
      else if (s_axi_araddr == OFS_MASK)
        s_axi_rdata <= {24'h00_0000, mask};
      else if (s_axi_araddr == OFS_CTRL)
        s_axi_rdata <= {29'h0000_0000, ctrl};
      else if (s_axi_araddr == OFS_STATE)
        s_axi_rdata <= {29'h0000_0000, stat};
      else if (s_axi_araddr == OFS_COND)
        s_axi_rdata <= {24'h00_0000, cond_live};
      else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // interrupt line
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn)
      interrupt_request_n <= 1'b1;
    else
      interrupt_request_n <= ~|(next_status & ~mask);
  end

  // ==========================================================
  // rate and application select
  // ==========================================================
  logic [1:0] sel_req;
  assign sel_req = {ctrl.app_sel, ctrl.rate_sel};

  // bandwidth follows after a short settle; conform flag shows it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bandwidth_select <= 2'b00;
      settle_cnt <= '0;
    end else if (sel_req == bandwidth_select) begin
      settle_cnt <= '0;
    end else if (settle_cnt >= 32'(SETTLE_CYCLES / 1024)) begin
      bandwidth_select <= sel_req;
      settle_cnt <= '0;
    end else begin
      settle_cnt <= settle_cnt + 32'h0000_0001;
    end
  end

  assign stat.ready = (state == MMST_READY);
  assign stat.bw_conform = (sel_req == bandwidth_select);
  assign stat.in_reset = (state == MMST_RESET);

endmodule // mmst_top

// ### tb/mmst_checker.sv
`timescale 1ns/10ps
// ============================================================
// bus and interrupt checker
// ============================================================
module mmst_checker
  import mmst_pkg::*;
#(
  parameter longint INIT_CYCLES = INIT_CYC,
  parameter int SETTLE_CYCLES = RATESEL_CYC,
  parameter int LOS_CLEAR_CYCLES = LOS_FAST_CLEAR_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic module_reset_n,
  input wire logic [NFLAG-2:0] condition,
  input wire logic interrupt_request_n,
  input wire logic management_setup_state
);
  localparam int INIT_BOUND = 12;
  logic rd_stat;
  logic [6:0] quiet_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_stat <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_stat <= (s_axi_araddr == OFS_STATUS);
    end
  end

  // filter and loss hold must have drained before a read can clear
  always_ff @(posedge aclk) begin
    if (!aresetn || condition != '0) begin
      quiet_cnt <= 7'h00;
    end else if (quiet_cnt != 7'h40) begin
      quiet_cnt <= quiet_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence restarted;
    ##[1:8] management_setup_state ##[1:INIT_BOUND] !management_setup_state;
  endsequence

  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2 && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  chk_setup_done: assert property ($rose(aresetn) |-> ##[1:INIT_BOUND]
    !management_setup_state) else $error("setup too long");
  chk_link_restart: assert property ($rose(module_reset_n) |-> restarted)
    else $error("pin reset ignored");
  chk_irq_release: assert property (rd_stat && s_axi_rvalid && s_axi_rready
    && quiet_cnt == 7'h40 |-> ##[1:3] interrupt_request_n)
    else $error("interrupt held after read");
endmodule // mmst_checker

bind mmst_top mmst_checker #(.INIT_CYCLES(INIT_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES), .LOS_CLEAR_CYCLES(LOS_CLEAR_CYCLES)) u_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .module_reset_n, .condition, .interrupt_request_n,
  .management_setup_state);

// ### tb/mmst_host_model.sv
`timescale 1ns/10ps
// ============================================================
// host side of the reset pin
// ============================================================
module mmst_host_model
  import mmst_pkg::*;
(
  // clock
  input wire logic aclk,
  // request
  input wire logic pulse_req,
  // pin
  output logic module_reset_n
);
  int cnt = 0;
  // pin low exactly while the count runs
  assign module_reset_n = (cnt == 0);
  // shortest legal pulse, the hardest case for the module
  always @(posedge aclk) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (pulse_req) begin
      cnt <= RESET_CYC;
    end
  end
endmodule // mmst_host_model

// ### tb/module_mgmt_status_timing_bench.sv
`timescale 1ns/10ps
module module_mgmt_status_timing_bench;
  import mmst_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_req;
  logic module_reset_n, interrupt_request_n, management_setup_state;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, bit_v, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bandwidth_select;
  logic [NFLAG-2:0] condition;
  logic [33:0] exp_q[$];
  logic [33:0] got, exp;
  int err_total, tests_run, seed, b_r;

  mmst_top #(.INIT_CYCLES(2048), .SETTLE_CYCLES(1024),
    .LOS_CLEAR_CYCLES(640)) DUT (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .module_reset_n, .condition, .interrupt_request_n,
    .management_setup_state, .bandwidth_select);
  mmst_host_model host (.aclk, .pulse_req, .module_reset_n);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ============================================================
  // bus master
  // ============================================================
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           input logic [1:0] r);
    int n;
    bit aw, w, b;
    exp_q.push_back({r, 32'h0000_0000});
    {aw, w, b, n} = '0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b && n < 200) begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      b = s_axi_bvalid;
    end
    if (!b) begin
      check(0, "write hung");
      summarize();
    end
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [1:0] r,
                          input logic [31:0] v);
    int n;
    bit ar, rv;
    exp_q.push_back({r, v});
    {ar, rv, n} = '0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!rv && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ar && s_axi_arready) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      rv = s_axi_rvalid;
    end
    if (!rv) begin
      check(0, "read hung");
      summarize();
    end
  endtask

  // sel 0 interrupt, 1 setup state, 2 bandwidth
  task automatic wait_lvl(input int sel, input logic [1:0] lvl);
    int n;
    logic [1:0] cur;
    n = 0;
    do begin
      cur = (sel == 0) ? {1'b0, interrupt_request_n} :
            (sel == 1) ? {1'b0, management_setup_state} : bandwidth_select;
      if (cur !== lvl) begin
        @(posedge aclk);
      end
      n++;
    end while (cur !== lvl && n < 2000);
    check(cur === lvl, "level not reached");
    if (cur !== lvl) begin
      summarize();
    end
  endtask

  // answers are matched against the oldest note
  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      got = s_axi_bvalid ? {s_axi_bresp, 32'h0000_0000} :
                           {s_axi_rresp, s_axi_rdata};
      exp = exp_q.pop_front();
      check(got === exp, "bus answer");
    end
  end

  // ============================================================
  // scenarios
  // ============================================================
  initial begin
    {err_total, tests_run, seed} = {32'h0, 32'h0, 32'h5809};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, pulse_req, condition} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wait_lvl(1, 2'h0);
    axi_read(OFS_MASK, 2'h0, 32'h0000_00FF);
    axi_read(OFS_CTRL, 2'h0, 32'h0000_0000);
    axi_read(OFS_STATUS, 2'h0, 32'h0000_0080);
    axi_read(OFS_STATUS, 2'h0, 32'h0000_0000);
    axi_read(8'h20, 2'h2, 32'h0000_0000);
    axi_write(8'h24, 32'h0000_0001, 2'h2);
    $display("test reset done");
    for (int b = 0; b < 7; b++) begin
      bit_v = 32'h0000_0001 << b;
      axi_write(OFS_MASK, 32'h0000_00FF ^ bit_v, 2'h0);
      condition <= bit_v[6:0];
      wait_lvl(0, 2'h0);
      axi_read(OFS_STATUS, 2'h0, bit_v);
      condition <= '0;
      repeat (64) @(posedge aclk);
      axi_read(OFS_STATUS, 2'h0, bit_v);
      wait_lvl(0, 2'h1);
      axi_read(OFS_STATUS, 2'h0, 32'h0000_0000);
    end
    $display("test flags done");
    b_r = $unsigned($random(seed)) % 7;
    bit_v = 32'h0000_0001 << b_r;
    axi_write(OFS_MASK, 32'h0000_00FF, 2'h0);
    condition <= bit_v[6:0];
    repeat (64) @(posedge aclk);
    check(interrupt_request_n === 1'b1, "masked flag raised");
    axi_write(OFS_MASK, 32'h0000_00FF ^ bit_v, 2'h0);
    wait_lvl(0, 2'h0);
    axi_write(OFS_MASK, 32'h0000_00FF, 2'h0);
    wait_lvl(0, 2'h1);
    condition <= '0;
    repeat (64) @(posedge aclk);
    axi_read(OFS_STATUS, 2'h0, bit_v);
    $display("test mask done");
    for (int i = 0; i < 4; i++) begin
      d = {29'h0, i[1:0], 1'($random(seed))};
      axi_write(OFS_CTRL, d, 2'h0);
      wait_lvl(2, d[2:1]);
      axi_read(OFS_CTRL, 2'h0, d);
    end
    axi_read(OFS_STATE, 2'h0, 32'h0000_0006);
    $display("test select done");
    axi_write(OFS_MASK, 32'h0000_00FE, 2'h0);
    axi_write(OFS_CTRL, 32'h0000_0007, 2'h0);
    condition <= 7'h01;
    wait_lvl(0, 2'h0);
    axi_read(OFS_COND, 2'h0, 32'h0000_0001);
    condition <= 7'h00;
    repeat (64) @(posedge aclk);
    axi_read(OFS_COND, 2'h0, 32'h0000_0000);
    axi_read(OFS_STATUS, 2'h0, 32'h0000_0001);
    wait_lvl(0, 2'h1);
    $display("test fast loss done");
    pulse_req <= 1'b1;
    @(posedge aclk);
    pulse_req <= 1'b0;
    wait_lvl(1, 2'h1);
    wait_lvl(1, 2'h0);
    axi_read(OFS_STATUS, 2'h0, 32'h0000_0080);
    $display("test pin reset done");
    summarize();
  end
endmodule // module_mgmt_status_timing_bench
